// file: core/acld_map.vh
// constants for the ac link detect and inactive lane block
// ----------------------------------------------------------------------------
// Functional notes
// RQ1 - control lane undriven with AC support: wait 700us after power good, flag, detect
// RQ2 - enter AC detect only when DC detection found no partner
// RQ3 - in AC detect ramp transmit PLL to 1200MHz, receiver AC terminated
// RQ4 - while reset asserted in AC detect all transmitters ground terminated
// RQ5 - after reset release pull up only true pad of data lane 0
// RQ6 - observe lane 0 ramp for less than 13ms after reset release
// RQ7 - decide detection between 13 and 13.1ms after reset release
// RQ8 - slow ramp means receiver found: set retry enable
// RQ9 - on detection data lanes 7:0 and control idle, clock lane active
// RQ10 - on detection set coding, scrambler and de-emphasis enables
// RQ11 - transmitter enters training 0 once clock lane is at 1200MHz
// RQ12 - receiver enters training 0 at 13.2ms if receiver ready
// RQ13 - no receiver: set fail, end of chain, tx off; power down
// RQ14 - pads not at threshold within 13ms: treat as no receiver
// RQ15 - second sample point between active and disabled receiver ramp times
// RQ16 - termination valid before reset release; clock at 1200MHz by 13.1ms
// RQ17 - host must not disturb link until operational; 22ms timer advised
// RQ18 - software may time out and set transmitter off
// RQ19 - link stop with settings 00,10,11/01: freeze data eye within 100ns
// RQ20 - settings 10 or 11/01: keep scrambled data 200 to 300ns
// RQ21 - lanes disconnected by link stop return to inactive after training
// RQ22 - refresh command moves inactive lanes below width to refresh
// RQ23 - after width increase: reset to warm reset, link stop to disconnected
// RQ24 - ungangable-less 16 bit AC device sends pattern one on upper lanes
// RQ25 - crossing after first sample point means receiver present (code counts it present only up to the second sample point, T_SMP2)
// ----------------------------------------------------------------------------
`ifndef ACLD_MAP_VH
`define ACLD_MAP_VH
// apb register offsets
`define ACLD_REG_CTRL      12'h000
`define ACLD_REG_STATUS    12'h004
`define ACLD_REG_INACTIVE  12'h008
// control register fields
`define ACLD_CTRL_TRANSMITTER_OFF    0
`define ACLD_CTRL_ACSUP    1
`define ACLD_CTRL_NOUNG    2
`define ACLD_CTRL_SLEEP_SELECT    4
`define ACLD_CTRL_INLN     6
`define ACLD_CTRL_WIDTH    8
`define ACLD_CTRL_RESET    32'h0000_0002
// times in ns and cycle counts at 5 ns
`define ACLD_PCLK_NS       5
`define ACLD_T_POWER_GOOD_NS    700000
`define ACLD_T_SAMPLE1_NS  18000
`define ACLD_T_SAMPLE2_NS  750000
`define ACLD_T_OBSERVE_NS  13000000
`define ACLD_T_DECIDE_NS   13050000
`define ACLD_T_RXT0_NS     13200000
`define ACLD_T_FREEZE_NS   100
`define ACLD_T_SCRMIN_NS   200
`define ACLD_T_SCRMAX_NS   300
`define ACLD_CYC(ns)       (((ns) + `ACLD_PCLK_NS - 1) / `ACLD_PCLK_NS)
`endif

// file: core/acld_sync.v
// two flop synchroniser for a level from another domain
`timescale 1ns/1ps
module acld_sync (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // level
  input  wire d,
  output reg  q
);
  reg meta;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // acld_sync

// file: core/acld_timer.v
// saturating cycle counter restarted by a pulse
`timescale 1ns/1ps
module acld_timer (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // control
  input  wire        restart,
  input  wire        run,
  output reg  [23:0] count
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      count <= 24'h000000;
    else if (restart)
      count <= 24'h000000;
    else if (run && count != 24'hFFFFFF)
      count <= count + 24'h000001;
  end
endmodule // acld_timer

// file: core/acld_core.v
// ac link detect and inactive lane controller with apb registers
`timescale 1ns/1ps
`include "acld_map.vh"
module acld_core #(
  parameter T_POWER_GOOD  = `ACLD_CYC(`ACLD_T_POWER_GOOD_NS),
  parameter T_SMP1   = `ACLD_CYC(`ACLD_T_SAMPLE1_NS),
  parameter T_SMP2   = `ACLD_CYC(`ACLD_T_SAMPLE2_NS),
  parameter T_OBS    = `ACLD_T_OBSERVE_NS / `ACLD_PCLK_NS,
  parameter T_DECIDE = `ACLD_CYC(`ACLD_T_DECIDE_NS),
  parameter T_RXT0   = `ACLD_CYC(`ACLD_T_RXT0_NS)
) (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // link side inputs
  input  wire        power_good,
  input  wire        link_reset_n,
  input  wire        link_stop_request_n,
  input  wire        link_clk,
  input  wire        dc_detect_failed,
  input  wire        ctl_driven,
  input  wire        pad_above_threshold,
  input  wire        pll_locked_1200,
  input  wire        rx_ready,
  input  wire        training_done,
  input  wire        refresh_active,
  input  wire        width_increased,
  // lane controls
  output reg         pll_ramp_1200,
  output reg         rx_ac_termination,
  output reg         tx_ground_terminated,
  output reg         tx_detect_pullup,
  output reg         tx_electrical_idle,
  output reg         tx_active_drive,
  output reg         tx_training0,
  output reg         rx_training0,
  output reg         powered_down_state,
  // inactive lane controls
  output reg  [1:0]  inactive_state,
  output reg         rx_eye_freeze,
  output reg         tx_scrambled_data,
  output reg         training_pattern_one,
  output reg         warm_reset_request
);
  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam S_IDLE   = 3'd0;
  localparam S_WAIT   = 3'd1;
  localparam S_RESET  = 3'd2;
  localparam S_RAMP   = 3'd3;
  localparam S_FOUND  = 3'd4;
  localparam S_TRAIN  = 3'd5;
  localparam S_OFF    = 3'd6;
  localparam L_INACT  = 2'd0;
  localparam L_DISC   = 2'd1;
  localparam L_REFR   = 2'd2;
  localparam L_WARM   = 2'd3;
  localparam [8:0] T_SCRL = `ACLD_CYC(`ACLD_T_SCRMIN_NS);

  // --------------------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------------------
  wire s_pg, s_rst_n, s_stop_n, s_lclk, s_pad, s_ctl;
  acld_sync u_s0 (.pclk(pclk), .presetn(presetn), .d(power_good),          .q(s_pg));
  acld_sync u_s1 (.pclk(pclk), .presetn(presetn), .d(link_reset_n),        .q(s_rst_n));
  acld_sync u_s2 (.pclk(pclk), .presetn(presetn), .d(link_stop_request_n), .q(s_stop_n));
  acld_sync u_s3 (.pclk(pclk), .presetn(presetn), .d(link_clk),            .q(s_lclk));
  acld_sync u_s4 (.pclk(pclk), .presetn(presetn), .d(pad_above_threshold), .q(s_pad));
  acld_sync u_s5 (.pclk(pclk), .presetn(presetn), .d(ctl_driven),          .q(s_ctl));

  // link clock edge counter shows that the link clock runs
  reg       lclk_d;
  reg [7:0] lclk_edges;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_d     <= 1'b0;
      lclk_edges <= 8'h00;
    end else begin
      lclk_d <= s_lclk;
      if (s_lclk && !lclk_d)
        lclk_edges <= lclk_edges + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg  [31:0] ctrl;
  reg         ac_flag, retry_enable, coding_enable, scrambler_enable, deemphasis_enable;
  reg         link_fail_flag, end_of_chain;
  reg         tx_off_set;
  reg  [2:0]  state;
  wire        wr = psel && penable && pwrite;
  wire        transmitter_off = ctrl[`ACLD_CTRL_TRANSMITTER_OFF];
  wire        ac_supported    = ctrl[`ACLD_CTRL_ACSUP];
  wire        no_unganging    = ctrl[`ACLD_CTRL_NOUNG];
  wire [1:0]  sleep_select    = ctrl[`ACLD_CTRL_SLEEP_SELECT+1:`ACLD_CTRL_SLEEP_SELECT];
  wire [1:0]  inactive_lane_setting = ctrl[`ACLD_CTRL_INLN+1:`ACLD_CTRL_INLN];
  wire [1:0]  link_width_setting    = ctrl[`ACLD_CTRL_WIDTH+1:`ACLD_CTRL_WIDTH];

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl <= `ACLD_CTRL_RESET;
    else begin
      if (wr && paddr == `ACLD_REG_CTRL)
        ctrl <= pwdata;
      if (tx_off_set)
        ctrl[`ACLD_CTRL_TRANSMITTER_OFF] <= 1'b1; // [RQ13]
    end
  end

  always @* begin
    case (paddr)
      `ACLD_REG_CTRL:     prdata = ctrl;
      `ACLD_REG_STATUS:   prdata = {16'h0000, lclk_edges, 1'b0, state, link_fail_flag,
                                    end_of_chain, retry_enable, ac_flag};
      `ACLD_REG_INACTIVE: prdata = {24'h000000, 1'b0, deemphasis_enable, scrambler_enable,
                                    coding_enable, 2'b00, inactive_state};
      default:            prdata = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // ac detect sequence
  // --------------------------------------------------------------------------
  reg         early_cross, crossed;
  wire [23:0] tcount;
  wire        restart = (state == S_RESET && s_rst_n) || (state == S_IDLE && s_pg);
  acld_timer u_tmr (.pclk(pclk), .presetn(presetn), .restart(restart),
                    .run(1'b1), .count(tcount));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      ac_flag <= 1'b0;
      retry_enable <= 1'b0;
      coding_enable <= 1'b0;
      scrambler_enable <= 1'b0;
      deemphasis_enable <= 1'b0;
      link_fail_flag <= 1'b0;
      end_of_chain <= 1'b0;
      tx_off_set <= 1'b0;
      early_cross <= 1'b0;
      crossed <= 1'b0;
      tx_training0 <= 1'b0;
      rx_training0 <= 1'b0;
    end else begin
      tx_off_set <= 1'b0;
      if (!s_pg)
        state <= S_IDLE;
      else if (transmitter_off && state != S_IDLE)
        state <= S_OFF;
      else
        case (state)
          S_IDLE: if (dc_detect_failed && !s_ctl && ac_supported) state <= S_WAIT; // [RQ2]
          S_WAIT: if (tcount >= T_POWER_GOOD) begin // [RQ1]
            ac_flag <= 1'b1;
            state <= S_RESET;
          end
          S_RESET: if (s_rst_n) begin
            early_cross <= 1'b0;
            crossed <= 1'b0;
            state <= S_RAMP;
          end
          S_RAMP: begin
            if (s_pad && !crossed) begin
              crossed <= 1'b1;
              if (tcount < T_SMP1) early_cross <= 1'b1; // [RQ25]
              if (tcount > T_SMP2) early_cross <= 1'b1; // [RQ15]
            end
            if (tcount >= T_DECIDE) begin // [RQ7]
              if (crossed && !early_cross && tcount >= T_OBS) begin // [RQ6] [RQ14]
                retry_enable <= 1'b1; // [RQ8]
                coding_enable <= 1'b1; // [RQ10]
                scrambler_enable <= 1'b1;
                deemphasis_enable <= 1'b1;
                state <= S_FOUND;
              end else begin
                link_fail_flag <= 1'b1; // [RQ13]
                end_of_chain <= 1'b1;
                tx_off_set <= 1'b1;
                state <= S_OFF;
              end
            end
          end
          S_FOUND: begin
            if (pll_locked_1200) tx_training0 <= 1'b1; // [RQ11] [RQ16]
            if (tcount >= T_RXT0 && rx_ready) rx_training0 <= 1'b1; // [RQ12]
            if (tx_training0 && rx_training0) state <= S_TRAIN;
          end
          S_TRAIN: state <= S_TRAIN;
          S_OFF:   if (!transmitter_off) state <= S_IDLE;
          default: state <= S_IDLE;
        endcase
    end
  end

  // --------------------------------------------------------------------------
  // pad mode decode
  // --------------------------------------------------------------------------
  reg         next_pll_ramp;
  reg         next_rx_term;
  reg         next_gnd_term;
  reg         next_pullup;
  reg         next_tx_idle;
  reg         next_tx_drive;
  reg         next_power_down;
  // one row per state keeps pull-up and ground termination exclusive
  always @* begin
    next_pll_ramp   = 1'b0;
    next_rx_term    = 1'b0;
    next_gnd_term   = 1'b0;
    next_pullup     = 1'b0;
    next_tx_idle    = 1'b0;
    next_tx_drive   = 1'b0;
    next_power_down = 1'b0;
    case (state)
      S_IDLE: begin
        next_gnd_term = 1'b1;
      end
      S_WAIT: begin
        next_pll_ramp = 1'b1; // [RQ3]
        next_rx_term  = 1'b1; // [RQ16]
        next_gnd_term = 1'b1;
      end
      S_RESET: begin
        next_pll_ramp = 1'b1; // [RQ3]
        next_rx_term  = 1'b1; // [RQ3] [RQ16]
        next_gnd_term = 1'b1; // [RQ4]
      end
      S_RAMP: begin
        next_pll_ramp = 1'b1;
        next_rx_term  = 1'b1;
        next_pullup   = 1'b1; // [RQ5]
      end
      S_FOUND: begin
        next_pll_ramp = 1'b1;
        next_rx_term  = 1'b1;
        next_tx_idle  = 1'b1; // [RQ9]
        next_tx_drive = 1'b1; // [RQ9]
      end
      S_TRAIN: begin
        next_pll_ramp = 1'b1;
        next_rx_term  = 1'b1;
        next_tx_drive = 1'b1;
      end
      S_OFF: begin
        next_rx_term    = 1'b1;
        next_gnd_term   = 1'b1;
        next_power_down = 1'b1; // [RQ13]
      end
      default: begin
        next_rx_term  = 1'b1;
        next_gnd_term = 1'b1;
      end
    endcase
  end

  // pad modes are registered copies of the decode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ramp_1200 <= 1'b0;
      rx_ac_termination <= 1'b0;
      tx_ground_terminated <= 1'b1;
      tx_detect_pullup <= 1'b0;
      tx_electrical_idle <= 1'b0;
      tx_active_drive <= 1'b0;
      powered_down_state <= 1'b0;
    end else begin
      pll_ramp_1200 <= next_pll_ramp;
      rx_ac_termination <= next_rx_term;
      tx_ground_terminated <= next_gnd_term;
      tx_detect_pullup <= next_pullup;
      tx_electrical_idle <= next_tx_idle;
      tx_active_drive <= next_tx_drive;
      powered_down_state <= next_power_down;
    end
  end

  // --------------------------------------------------------------------------
  // inactive lanes
  // --------------------------------------------------------------------------
  wire       freeze_case = (inactive_lane_setting == 2'b00) || (inactive_lane_setting == 2'b10)
                           || (inactive_lane_setting == 2'b11 && sleep_select == 2'b01);
  wire       scr_case    = (inactive_lane_setting == 2'b10)
                           || (inactive_lane_setting == 2'b11 && sleep_select == 2'b01);
  reg  [8:0] stop_cnt;
  reg        stop_d;
  reg        stop_seen;
  // the synchroniser resets low, so a stop counts only once the pin has read idle high
  wire       stop_act  = !s_stop_n && stop_seen;
  wire       stop_edge = stop_act && !stop_d;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inactive_state <= L_INACT;
      rx_eye_freeze <= 1'b0;
      tx_scrambled_data <= 1'b0;
      training_pattern_one <= 1'b0;
      warm_reset_request <= 1'b0;
      stop_cnt <= 9'h000;
      stop_d <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      stop_d <= stop_act;
      if (s_stop_n)
        stop_seen <= 1'b1;
      if (!stop_act)
        stop_cnt <= 9'h000;
      else if (stop_cnt != 9'h1FF)
        stop_cnt <= stop_cnt + 9'h001;
      // the eye stays frozen for as long as the stop lasts
      rx_eye_freeze <= stop_act && freeze_case; // [RQ19]
      tx_scrambled_data <= (stop_act && scr_case && stop_cnt < T_SCRL)
                           || (!stop_act && inactive_state == L_INACT); // [RQ20]
      training_pattern_one <= no_unganging && ac_flag && inactive_lane_setting == 2'b10
                              && inactive_state == L_INACT; // [RQ24]
      warm_reset_request <= 1'b0;
      case (inactive_state)
        L_INACT: begin
          if (stop_edge && (freeze_case || width_increased))
            inactive_state <= L_DISC; // [RQ23]
          else if (width_increased && !s_rst_n) begin
            inactive_state <= L_WARM; // [RQ23]
            warm_reset_request <= 1'b1;
          end else if (refresh_active && link_width_setting != 2'b00)
            inactive_state <= L_REFR; // [RQ22]
        end
        L_DISC:  if (training_done) inactive_state <= L_INACT; // [RQ21]
        L_REFR:  if (!refresh_active) inactive_state <= L_INACT; // [RQ22]
        L_WARM:  if (s_rst_n) inactive_state <= L_INACT;
        default: inactive_state <= L_INACT;
      endcase
    end
  end
endmodule // acld_core

// file: bench/acld_chk_sva.sv
// checker for the ac link detect block, bound to its top module
`timescale 1ns/1ps
module acld_chk #(
  parameter int T_OBS    = 100,
  parameter int T_DECIDE = 110,
  parameter int T_RXT0   = 130
) (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // link inputs
  input logic link_reset_n,
  input logic link_stop_request_n,
  input logic pll_locked_1200,
  input logic rx_ready,
  // lane controls
  input logic pll_ramp_1200,
  input logic rx_ac_termination,
  input logic tx_ground_terminated,
  input logic tx_detect_pullup,
  input logic tx_electrical_idle,
  input logic tx_active_drive,
  input logic tx_training0,
  input logic rx_training0,
  input logic powered_down_state,
  input logic rx_eye_freeze
);
  logic [15:0] since;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the link reset was last released, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since <= 16'h0000;
    else if (!link_reset_n) since <= 16'h0000;
    else if (since != 16'hFFFF) since <= since + 16'h0001;
  end
  ramp_term_a: assert property (pll_ramp_1200 |-> rx_ac_termination)
    else $error("pll ramps without ac termination");
  pull_not_gnd_a: assert property (tx_detect_pullup |-> !tx_ground_terminated)
    else $error("pull-up while ground terminated");
  pull_after_rst_a: assert property ($rose(tx_detect_pullup) |-> link_reset_n)
    else $error("pull-up before link reset release");
  idle_clk_drive_a: assert property (tx_electrical_idle |->
      tx_active_drive && !powered_down_state)
    else $error("idle lanes without clock drive");
  decide_window_a: assert property ($rose(tx_electrical_idle) |->
      since >= T_OBS && since <= T_DECIDE + 8)
    else $error("detection decided outside window");
  tx_t0_lock_a: assert property ($rose(tx_training0) |-> $past(pll_locked_1200))
    else $error("tx training before clock lock");
  rx_t0_time_a: assert property ($rose(rx_training0) |->
      $past(rx_ready) && since >= T_RXT0)
    else $error("rx training early or not ready");
  freeze_time_a: assert property ($fell(link_stop_request_n) |-> ##[1:20] rx_eye_freeze)
    else $error("eye not frozen in time");
  found_c: cover property ($rose(tx_training0));
  fail_c: cover property ($rose(powered_down_state));
  freeze_c: cover property ($rose(rx_eye_freeze));
endmodule // acld_chk
bind acld_core acld_chk #(.T_OBS(T_OBS), .T_DECIDE(T_DECIDE), .T_RXT0(T_RXT0)) u_chk (
  .pclk, .presetn, .link_reset_n, .link_stop_request_n, .pll_locked_1200, .rx_ready,
  .pll_ramp_1200, .rx_ac_termination, .tx_ground_terminated, .tx_detect_pullup,
  .tx_electrical_idle, .tx_active_drive, .tx_training0, .rx_training0,
  .powered_down_state, .rx_eye_freeze);

// file: bench/acld_peer.sv
// model of the ac coupled peer and the analog pad and pll behaviour
`timescale 1ns/1ps
module acld_peer (
  // clock and setup
  input  logic pclk,
  input  logic power_good,
  input  int   pad_dly,
  // from the device
  input  logic tx_detect_pullup,
  input  logic pll_ramp_1200,
  // to the device
  output logic pad_above_threshold,
  output logic link_clk,
  output logic pll_locked_1200,
  output logic rx_ready,
  output logic ctl_driven
);
  int ramp_cnt = 0;
  int lock_cnt = 0;
  // an ac coupled peer never drives dc levels on the control lane
  assign ctl_driven = 1'b0;
  always @(posedge pclk) begin
    ramp_cnt <= tx_detect_pullup ? ramp_cnt + 1 : 0;
    lock_cnt <= pll_ramp_1200 ? lock_cnt + 1 : 0;
  end
  // zero delay models a shorted pad that never crosses
  assign pad_above_threshold = tx_detect_pullup && pad_dly > 0 && ramp_cnt >= pad_dly;
  assign pll_locked_1200 = lock_cnt >= 8;
  assign rx_ready = pll_locked_1200;
  initial link_clk = 1'b0;
  always #80 link_clk = power_good ? ~link_clk : 1'b0;
endmodule // acld_peer

// file: bench/tb_ac_link_detect_and_inactive_lanes.sv
// self-checking bench for the ac link detect and inactive lane block
`timescale 1ns/1ps
module tb_ac_link_detect_and_inactive_lanes;
  localparam int T_POWER_GOOD = 20;
  localparam int T_RXT0  = 130;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, rd2;
  logic        power_good = 1'b0, link_reset_n = 1'b0, link_stop_request_n = 1'b1;
  logic        dc_detect_failed = 1'b0, training_done = 1'b0, refresh_active = 1'b0;
  logic        width_increased = 1'b0, warm_seen = 1'b0, idle_seen = 1'b0;
  wire  [31:0] prdata;
  wire  [1:0]  inactive_state;
  wire         pready, pslverr, link_clk, ctl_driven, pad_above_threshold, pll_locked_1200;
  wire         rx_ready, pll_ramp_1200, rx_ac_termination, tx_ground_terminated;
  wire         tx_detect_pullup, tx_electrical_idle, tx_active_drive, tx_training0;
  wire         rx_training0, powered_down_state, rx_eye_freeze, tx_scrambled_data;
  wire         training_pattern_one, warm_reset_request;
  int          pad_dly = 0, mismatches = 0, n_tests = 0;
  int          fail_dly[3] = '{1, 0, 80};
  acld_core #(.T_POWER_GOOD(T_POWER_GOOD), .T_SMP1(8), .T_SMP2(40), .T_OBS(100), .T_DECIDE(110),
              .T_RXT0(T_RXT0)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_good, .link_reset_n, .link_stop_request_n, .link_clk, .dc_detect_failed,
    .ctl_driven, .pad_above_threshold, .pll_locked_1200, .rx_ready, .training_done,
    .refresh_active, .width_increased, .pll_ramp_1200, .rx_ac_termination,
    .tx_ground_terminated, .tx_detect_pullup, .tx_electrical_idle, .tx_active_drive,
    .tx_training0, .rx_training0, .powered_down_state, .inactive_state, .rx_eye_freeze,
    .tx_scrambled_data, .training_pattern_one, .warm_reset_request);
  acld_peer peer (.pclk, .power_good, .pad_dly, .tx_detect_pullup, .pll_ramp_1200,
    .pad_above_threshold, .link_clk, .pll_locked_1200, .rx_ready, .ctl_driven);
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (warm_reset_request === 1'b1) warm_seen <= 1'b1;
  always @(posedge pclk) idle_seen <= presetn && (idle_seen || tx_electrical_idle === 1'b1);
  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic boot(input int dly, input logic dcf);
    presetn <= 1'b0;
    power_good <= 1'b0;
    link_reset_n <= 1'b0;
    dc_detect_failed <= dcf;
    pad_dly <= dly;
    cyc(5);
    chk(tx_ground_terminated, 1'b1);
    presetn <= 1'b1;
    power_good <= 1'b1;
    cyc(T_POWER_GOOD + 10);
    chk({pll_ramp_1200, rx_ac_termination}, {dcf, dcf});
    chk(tx_detect_pullup, 1'b0);
    link_reset_n <= 1'b1;
    cyc(T_RXT0 + 20);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    boot(20, 1'b1);
    chk({idle_seen, tx_electrical_idle, tx_active_drive}, 3'b101);
    chk({tx_training0, rx_training0, powered_down_state}, 3'b110);
    apb(1'b0, 12'h004, 32'h0, rd);
    chk(rd & 32'hF, 32'h3);
    apb(1'b0, 12'h008, 32'h0, rd);
    chk(rd & 32'h70, 32'h70);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF, rd);
    apb(1'b0, 12'h0FC, 32'h0, rd);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0, rd);
    cyc(64);
    apb(1'b0, 12'h004, 32'h0, rd2);
    chk(rd2[15:8] != rd[15:8], 1'b1);
    apb(1'b1, 12'h000, 32'h0000_0186, rd);
    apb(1'b0, 12'h000, 32'h0, rd);
    chk({rd, training_pattern_one}, {32'h0000_0186, 1'b1});
    link_stop_request_n <= 1'b0;
    cyc(24);
    chk(rx_eye_freeze, 1'b1);
    cyc(10);
    chk(tx_scrambled_data, 1'b1);
    cyc(40);
    chk({tx_scrambled_data, inactive_state}, 3'b001);
    link_stop_request_n <= 1'b1;
    training_done <= 1'b1;
    cyc(8);
    chk(inactive_state, 2'd0);
    refresh_active <= 1'b1;
    cyc(8);
    chk(inactive_state, 2'd2);
    width_increased <= 1'b1;
    refresh_active <= 1'b0;
    link_reset_n <= 1'b0;
    cyc(8);
    chk({inactive_state, warm_seen}, 3'b111);
    apb(1'b1, 12'h000, 32'h0000_0003, rd);
    cyc(4);
    chk(powered_down_state, 1'b1);
    width_increased <= 1'b0;
    foreach (fail_dly[i]) begin
      boot(fail_dly[i], 1'b1);
      chk({powered_down_state, tx_training0, rx_training0}, 3'b100);
      chk({tx_electrical_idle, idle_seen}, 2'b00);
      apb(1'b0, 12'h004, 32'h0, rd);
      apb(1'b0, 12'h000, 32'h0, rd2);
      chk({rd[3:0], rd2[0]}, 5'b11011);
    end
    boot(20, 1'b0);
    chk({tx_training0, powered_down_state}, 2'b00);
    conclude();
  end
  initial begin
    cyc(5000);
    mismatches++;
    conclude();
  end
endmodule // tb_ac_link_detect_and_inactive_lanes
